// File: shared/rtc_pkg.sv
package rtc_pkg;

   // ------------------------------------------------------------
   // Register indices
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_MONTH = 8'h08;
   localparam logic [7:0] IDX_YEAR  = 8'h09;
   localparam logic [7:0] IDX_A     = 8'h0a;
   localparam logic [7:0] IDX_B     = 8'h0b;
   localparam logic [7:0] IDX_C     = 8'h0c;
   localparam logic [7:0] RST_BYTE  = 8'h00;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int A_UIP  = 7;
   localparam int A_DVHI = 6;
   localparam int B_SET  = 7;
   localparam int B_PIE  = 6;
   localparam int B_UIE  = 4;
   localparam int B_SQWE = 3;
   localparam int B_DM   = 2;
   localparam int B_24H  = 1;
   localparam int B_DSE  = 0;
   localparam int C_IRQF = 7;

   // ------------------------------------------------------------
   // Divider codes and prescale counts
   // ------------------------------------------------------------
   localparam logic [2:0] DV_4M  = 3'h0;
   localparam logic [2:0] DV_1M  = 3'h1;
   localparam logic [7:0] PRE_4M  = 8'h80;
   localparam logic [7:0] PRE_1M  = 8'h20;
   localparam logic [7:0] PRE_32K = 8'h01;

   // ------------------------------------------------------------
   // Timing, from nanoseconds to time-base ticks of 1/32768 s
   // ------------------------------------------------------------
   localparam longint BASE_HZ = 32768;
   localparam longint LEAD_NS = 244000;
   localparam longint UPD_NS  = 1984000;
   localparam logic [14:0] LEAD_TICKS =
      15'((LEAD_NS * BASE_HZ + 64'd999999999) / 64'd1000000000);
   localparam logic [14:0] UPD_TICKS =
      15'((UPD_NS * BASE_HZ) / 64'd1000000000);
   localparam logic [14:0] LEAD_START = 15'h7fff - LEAD_TICKS + 15'h1;
   localparam logic [14:0] DIV_LAST   = 15'h7fff;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic       data_sel;
      logic [7:0] wdata;
   } io_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] month;
      logic [7:0] year;
   } cal_upd_t;

   typedef struct packed {
      logic sqwe;
      logic binary;
      logic hour24;
      logic dst;
   } mode_t;

   typedef enum logic [1:0] {
      UPD_IDLE = 2'b00,
      UPD_LEAD = 2'b01,
      UPD_BUSY = 2'b11
   } upd_state_t;

endpackage

// File: design/rtc_calendar_control.sv
`timescale 1ns/1ps
`default_nettype none

module rtc_calendar_control (
   // Clock and resets
   input  wire  logic              sys_clk,
   input  wire  logic              rst_n,
   input  wire  logic              supply_loss_reset_n,
   // Oscillator edge pulse
   input  wire  logic              osc_tick,
   // Index and data port access
   input  wire  rtc_pkg::io_req_t  io,
   output var   logic [7:0]        io_rdata_r,
   // Time-keeping side
   input  wire  logic              alarm_match,
   input  wire  rtc_pkg::cal_upd_t cal_in,
   output var   logic              update_start_r,
   output var   logic              update_end_r,
   output var   rtc_pkg::mode_t    mode_r,
   output var   logic [7:0]        month_r,
   output var   logic [7:0]        year_r,
   // Square wave and interrupt
   output var   logic              sqw_r,
   output var   logic              irq_r
);
   import rtc_pkg::*;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Mask of divider bits that must be all ones for a periodic event.
   function automatic logic [14:0] period_mask(input logic [3:0] rs);
      logic [14:0] m;
      m = 15'h0;
      for (int i = 0; i < 15; i++) begin
         if (i < int'(rs) - 1) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0]  idx_r;
   logic [6:0]  reg_a_r;
   logic [7:0]  reg_b_r;
   logic [2:0]  flags_r;
   logic        irqf_r;
   logic [7:0]  pre_r;
   logic [14:0] div_r;
   logic [14:0] upd_cnt_r;
   upd_state_t  st_r;
   upd_state_t  st_nxt;

   // ------------------------------------------------------------
   // Port decode
   // ------------------------------------------------------------
   wire logic idx_wr  = io.wr & ~io.data_sel;
   wire logic dat_wr  = io.wr & io.data_sel;
   wire logic dat_rd  = io.rd & io.data_sel;
   wire logic wr_mon  = dat_wr & (idx_r == IDX_MONTH);
   wire logic wr_yr   = dat_wr & (idx_r == IDX_YEAR);
   wire logic wr_a    = dat_wr & (idx_r == IDX_A);
   wire logic wr_b    = dat_wr & (idx_r == IDX_B);
   wire logic rd_c    = dat_rd & (idx_r == IDX_C);
   wire logic sup_rst = ~supply_loss_reset_n;

   // ------------------------------------------------------------
   // Prescaler and divider
   // ------------------------------------------------------------
   // A divider code with its top bit set parks the whole chain at zero.
   wire logic       dv_run = ~reg_a_r[A_DVHI];
   wire logic [2:0] dv     = reg_a_r[6:4];
   wire logic [7:0] pre_lim =
      (dv == DV_4M) ? PRE_4M :
      (dv == DV_1M) ? PRE_1M : PRE_32K;
   wire logic base_tick =
      dv_run & osc_tick & (pre_r == pre_lim - 8'h1);
   wire logic sec_wrap = base_tick & (div_r == DIV_LAST);
   wire logic [7:0] pre_nxt =
      ~dv_run   ? 8'h0 :
      base_tick ? 8'h0 :
      osc_tick  ? pre_r + 8'h1 : pre_r;
   wire logic [14:0] div_nxt =
      ~dv_run   ? 15'h0 :
      base_tick ? div_r + 15'h1 : div_r;

   // ------------------------------------------------------------
   // Periodic event and square wave
   // ------------------------------------------------------------
   wire logic [3:0]  rs   = reg_a_r[3:0];
   wire logic [14:0] pmsk = period_mask(rs);
   wire logic per_ev =
      base_tick & (rs != 4'h0) & ((div_r & pmsk) == pmsk);
   wire logic sqw_nxt =
      ~reg_b_r[B_SQWE] ? 1'b0 :
      per_ev ? ~sqw_r : sqw_r;

   // ------------------------------------------------------------
   // Update cycle sequencer
   // ------------------------------------------------------------
   // Inhibit or a stopped divider drops straight back to idle, so an
   // update that is running never reports its end.
   wire logic halt    = reg_b_r[B_SET] | ~dv_run;
   wire logic in_lead = div_r >= LEAD_START;
   wire logic upd_done =
      (st_r == UPD_BUSY) & ~halt & base_tick &
      (upd_cnt_r == UPD_TICKS - 15'h1);
   wire logic upd_go = (st_r == UPD_LEAD) & ~halt & sec_wrap;

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         UPD_IDLE: begin
            if (~halt & in_lead & ~sec_wrap) begin
               st_nxt = UPD_LEAD;
            end
         end
         UPD_LEAD: begin
            if (halt) begin
               st_nxt = UPD_IDLE;
            end else if (sec_wrap) begin
               st_nxt = UPD_BUSY;
            end
         end
         UPD_BUSY: begin
            if (halt | upd_done) begin
               st_nxt = UPD_IDLE;
            end
         end
         default: st_nxt = UPD_IDLE;
      endcase
   end

   wire logic [14:0] upd_cnt_nxt =
      upd_go ? 15'h0 :
      (st_r == UPD_BUSY && base_tick) ? upd_cnt_r + 15'h1 : upd_cnt_r;

   // Inhibit masks the flag from the cycle after it is written, before the state returns to idle.
   wire logic uip = (st_r != UPD_IDLE) & ~reg_b_r[B_SET];

   // ------------------------------------------------------------
   // Flags
   // ------------------------------------------------------------
   wire logic [2:0] en = reg_b_r[6:4];
   wire logic [2:0] ev = {per_ev, alarm_match, upd_done};
   // An event in the cycle of the clearing read survives the read.
   wire logic [2:0] flags_nxt =
      sup_rst ? 3'h0 :
      ((rd_c ? 3'h0 : flags_r) | ev);
   wire logic irqf_nxt =
      ~sup_rst & (|(flags_nxt & en));

   // ------------------------------------------------------------
   // Register next values
   // ------------------------------------------------------------
   wire logic [6:0] reg_a_nxt = wr_a ? io.wdata[6:0] : reg_a_r;
   wire logic [7:0] b_wr = wr_b ? io.wdata : reg_b_r;
   wire logic [7:0] reg_b_nxt =
      sup_rst ? {b_wr[7], 3'h0, b_wr[3:0]} : b_wr;
   wire logic [7:0] month_nxt =
      wr_mon ? io.wdata :
      (upd_done & cal_in.valid) ? cal_in.month : month_r;
   wire logic [7:0] year_nxt =
      wr_yr ? io.wdata :
      (upd_done & cal_in.valid) ? cal_in.year : year_r;
   wire mode_t mode_nxt = '{
      sqwe:   reg_b_r[B_SQWE],
      binary: reg_b_r[B_DM],
      hour24: reg_b_r[B_24H],
      dst:    reg_b_r[B_DSE]
   };

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   // Indices outside this group read as zero here.
   wire logic [7:0] rd_mux =
      (idx_r == IDX_MONTH) ? month_r :
      (idx_r == IDX_YEAR)  ? year_r :
      (idx_r == IDX_A)     ? {uip, reg_a_r} :
      (idx_r == IDX_B)     ? reg_b_r :
      (idx_r == IDX_C)     ? {irqf_r, flags_r, 4'h0} :
      RST_BYTE;
   wire logic [7:0] rdata_nxt =
      dat_rd ? rd_mux :
      io.rd  ? idx_r : io_rdata_r;

   // ------------------------------------------------------------
   // Flip-flops
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         idx_r   <= RST_BYTE;
         reg_a_r <= 7'h0;
         reg_b_r <= RST_BYTE;
         month_r <= RST_BYTE;
         year_r  <= RST_BYTE;
      end else begin
         idx_r   <= idx_wr ? io.wdata : idx_r;
         reg_a_r <= reg_a_nxt;
         reg_b_r <= reg_b_nxt;
         month_r <= month_nxt;
         year_r  <= year_nxt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pre_r     <= 8'h0;
         div_r     <= 15'h0;
         upd_cnt_r <= 15'h0;
         st_r      <= UPD_IDLE;
      end else begin
         pre_r     <= pre_nxt;
         div_r     <= div_nxt;
         upd_cnt_r <= upd_cnt_nxt;
         st_r      <= st_nxt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         flags_r <= 3'h0;
         irqf_r  <= 1'b0;
         irq_r   <= 1'b0;
      end else begin
         flags_r <= flags_nxt;
         irqf_r  <= irqf_nxt;
         irq_r   <= irqf_nxt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         io_rdata_r     <= RST_BYTE;
         update_start_r <= 1'b0;
         update_end_r   <= 1'b0;
         mode_r         <= '0;
         sqw_r          <= 1'b0;
      end else begin
         io_rdata_r     <= rdata_nxt;
         update_start_r <= upd_go;
         update_end_r   <= upd_done;
         mode_r         <= mode_nxt;
         sqw_r          <= sqw_nxt;
      end
   end

endmodule

`default_nettype wire

// File: testbench/rtc_calendar_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module rtc_calendar_control_chk (
   // Clock and resets
   input wire logic              sys_clk,
   input wire logic              rst_n,
   input wire logic              supply_loss_reset_n,
   // Inputs
   input wire logic              osc_tick,
   input wire rtc_pkg::io_req_t  io,
   input wire logic              alarm_match,
   input wire rtc_pkg::cal_upd_t cal_in,
   // Outputs
   input wire logic [7:0]        io_rdata_r,
   input wire logic              update_start_r,
   input wire logic              update_end_r,
   input wire rtc_pkg::mode_t    mode_r,
   input wire logic [7:0]        month_r,
   input wire logic [7:0]        year_r,
   input wire logic              sqw_r,
   input wire logic              irq_r
);
   import rtc_pkg::*;
   logic [7:0] idx_r;
   logic [7:0] b_r;
   wire        rd_data = io.rd && io.data_sel;
   wire        rd_c    = rd_data && idx_r == IDX_C;

   // Shadows of the index and of B, so answers can be tied to causes.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         idx_r <= 8'h00;
         b_r   <= 8'h00;
      end else begin
         if (io.wr && !io.data_sel)
            idx_r <= io.wdata;
         if (io.wr && io.data_sel && idx_r == IDX_B)
            b_r <= io.wdata;
         if (!supply_loss_reset_n)
            b_r[6:4] <= 3'h0;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_index_read: assert property (io.rd && !io.data_sel |=>
      io_rdata_r == $past(idx_r)) else $error("index read wrong");
   a_month_read: assert property (rd_data && idx_r == IDX_MONTH |=>
      io_rdata_r == $past(month_r)) else $error("month read wrong");
   a_flags_low_zero: assert property (rd_c |=>
      io_rdata_r[3:0] == 4'h0) else $error("reserved flag bits set");
   a_mode_copy: assert property (mode_r ==
      mode_t'($past(b_r[3:0]))) else $error("mode copy wrong");
   a_alarm_irq: assert property (alarm_match && b_r[5] &&
      supply_loss_reset_n |-> ##[1:2] irq_r) else $error("alarm lost");
   a_read_clears: assert property (rd_c && !b_r[6] && !alarm_match &&
      !$past(alarm_match) && !update_end_r && !$past(update_end_r)
      && supply_loss_reset_n |=> !irq_r || update_end_r)
      else $error("irq held");
   a_supply_clears: assert property (!supply_loss_reset_n |=>
      !irq_r) else $error("irq after supply loss");
   a_end_blocked: assert property (update_end_r |->
      !$past(b_r[7])) else $error("update ended while held");
endmodule

bind rtc_calendar_control rtc_calendar_control_chk rtc_calendar_control_chk_i (
   .sys_clk, .rst_n, .supply_loss_reset_n, .osc_tick, .io, .alarm_match,
   .cal_in, .io_rdata_r, .update_start_r, .update_end_r, .mode_r,
   .month_r, .year_r, .sqw_r, .irq_r);
`default_nettype wire

// File: testbench/rtc_calendar_control_test.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Self-checking bench
// ------------------------------------------------------------
module rtc_calendar_control_test;
   import rtc_pkg::*;
   logic       sys_clk = 1'b0;
   logic       rst_n, supply_loss_reset_n, osc_tick, alarm_match;
   io_req_t    io;
   cal_upd_t   cal_in;
   logic [7:0] io_rdata_r, month_r, year_r, d, m, y;
   logic       update_start_r, update_end_r, sqw_r, irq_r;
   mode_t      mode_r;
   logic [31:0] seed;
   int         num_errors, tests_run, i, n;

   always #5 sys_clk = ~sys_clk;

   rtc_calendar_control rtc_calendar_control_i (.sys_clk, .rst_n,
      .supply_loss_reset_n, .osc_tick, .io, .io_rdata_r, .alarm_match,
      .cal_in, .update_start_r, .update_end_r, .mode_r, .month_r, .year_r,
      .sqw_r, .irq_r);

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] bcd(input int v);
      return 8'((v / 10) * 16 + v % 10);
   endfunction

   task automatic give_verdict;
      if (num_errors == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] e,
                      input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic bound_hit(input int k, input int lim);
      if (k >= lim) begin
         num_errors++;
         give_verdict();
      end
   endtask
   // Strobes last exactly one cycle, so each step waits a falling edge.
   task automatic put(input logic [10:0] v);
      @(negedge sys_clk);
      io = io_req_t'(v);
   endtask
   task automatic wr_reg(input logic [7:0] idx, input logic [7:0] v);
      put({3'b010, idx});
      put({3'b011, v});
      put(11'h0);
   endtask
   task automatic rd_reg(input logic [7:0] idx, output logic [7:0] v);
      put({3'b010, idx});
      put({3'b101, 8'h00});
      put(11'h0);
      @(negedge sys_clk);
      v = io_rdata_r;
   endtask
   task automatic alarm_pulse;
      @(negedge sys_clk);
      alarm_match = 1'b1;
      @(negedge sys_clk);
      alarm_match = 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask

   initial begin
      rst_n = 1'b0;
      supply_loss_reset_n = 1'b1;
      osc_tick = 1'b0;
      alarm_match = 1'b0;
      io = '0;
      cal_in = '0;
      num_errors = 0;
      tests_run = 0;
      seed = 32'h857a;
      repeat (2) @(negedge sys_clk);
      rst_n = 1'b1;
      for (i = 8; i <= 12; i++) begin
         rd_reg(8'(i), d);
         chk("reset value", 8'h00, d);
      end
      for (i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         m = bcd(int'(seed % 12) + 1);
         y = bcd(int'(seed[15:0] % 100));
         wr_reg(IDX_MONTH, m);
         wr_reg(IDX_YEAR, y);
         rd_reg(IDX_MONTH, d);
         chk("month", m, d);
         rd_reg(IDX_YEAR, d);
         chk("year", y, d);
      end
      // Divider held in reset, so the top bit of A cannot be set by time.
      wr_reg(IDX_A, 8'hff);
      rd_reg(IDX_A, d);
      chk("reg A", 8'h7f, d);
      wr_reg(IDX_C, 8'hff);
      rd_reg(IDX_C, d);
      chk("reg C write", 8'h00, d);
      rd_reg(8'h0d, d);
      chk("unmapped", 8'h00, d);
      put({3'b100, 8'h00});
      put(11'h0);
      @(negedge sys_clk);
      chk("index read", 8'h0d, io_rdata_r);
      wr_reg(IDX_A, 8'h20);
      wr_reg(IDX_B, 8'h20);
      alarm_pulse();
      chk("irq alarm", 8'h01, {7'h0, irq_r});
      rd_reg(IDX_C, d);
      chk("reg C alarm", 8'ha0, d);
      chk("irq after read", 8'h00, {7'h0, irq_r});
      wr_reg(IDX_B, 8'h00);
      alarm_pulse();
      chk("irq masked", 8'h00, {7'h0, irq_r});
      rd_reg(IDX_C, d);
      chk("reg C masked", 8'h20, d);
      wr_reg(IDX_B, 8'hf7);
      alarm_pulse();
      @(negedge sys_clk);
      supply_loss_reset_n = 1'b0;
      @(negedge sys_clk);
      supply_loss_reset_n = 1'b1;
      chk("irq supply", 8'h00, {7'h0, irq_r});
      rd_reg(IDX_B, d);
      chk("reg B supply", 8'h87, d);
      rd_reg(IDX_C, d);
      chk("reg C supply", 8'h00, d);
      wr_reg(IDX_B, 8'h10);
      cal_in = {1'b1, 8'h12, 8'h99};
      osc_tick = 1'b1;
      n = 0;
      for (i = 0; i < 40000 && update_end_r !== 1'b1; i++) begin
         @(negedge sys_clk);
         n += int'(update_start_r === 1'b1);
      end
      bound_hit(i, 40000);
      chk("update start", 8'h01, 8'(n));
      repeat (3) @(negedge sys_clk);
      cal_in = '0;
      chk("irq update", 8'h01, {7'h0, irq_r});
      chk("month load", 8'h12, month_r);
      chk("year load", 8'h99, year_r);
      rd_reg(IDX_C, d);
      chk("reg C update", 8'h90, d);
      // Wait for the busy flag to rise, then set inhibit in the lead-in, before the pending update starts.
      d = 8'h00;
      for (i = 0; i < 15000 && d[7] !== 1'b1; i++)
         rd_reg(IDX_A, d);
      bound_hit(i, 15000);
      wr_reg(IDX_B, 8'h80);
      rd_reg(IDX_A, d);
      chk("reg A inhibit", 8'h20, d);
      n = 0;
      for (i = 0; i < 200; i++) begin
         @(negedge sys_clk);
         n += int'(update_end_r === 1'b1);
      end
      chk("end while inhibited", 8'h00, 8'(n));
      wr_reg(IDX_A, 8'h23);
      wr_reg(IDX_B, 8'hc0);
      repeat (8) @(negedge sys_clk);
      chk("irq periodic", 8'h01, {7'h0, irq_r});
      rd_reg(IDX_C, d);
      chk("reg C periodic", 8'hc0, d & 8'hc0);
      wr_reg(IDX_B, 8'h88);
      repeat (2) @(negedge sys_clk);
      chk("mode copy", 8'h08, {4'h0, mode_r});
      m = {7'h0, sqw_r};
      n = 0;
      for (i = 0; i < 16; i++) begin
         @(negedge sys_clk);
         n += int'(sqw_r !== m[0]);
         m = {7'h0, sqw_r};
      end
      chk("square toggles", 8'h04, 8'(n));
      give_verdict();
   end
endmodule
`default_nettype wire
